// File: rtl/ssp_pkg.sv
// shared constants and types of the serial port register block
// assumes a 125 MHz mclk and a word-addressed register index on the bus
package ssp_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] IDX_BUF = 10'h18C;
  localparam logic [9:0] IDX_DIV = 10'h18D;
  localparam logic [9:0] IDX_MASK = 10'h18E;
  localparam logic [9:0] IDX_STAT = 10'h18F;
  localparam logic [9:0] IDX_CTRL = 10'h1A0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [3:0] MODE_RST = 4'h0;

  // ****************************************************************
  // status register fields
  // ****************************************************************
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_DA = 5;
  localparam int STAT_P = 4;
  localparam int STAT_S = 3;
  localparam int STAT_RW = 2;
  localparam int STAT_UA = 1;
  localparam int STAT_BF = 0;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EN = 4;
  localparam int CTRL_STOP = 5;
  localparam int CTRL_COLL = 6;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [4:0] SPI_HALVES = 5'h10;
  localparam logic [4:0] I2C_HALVES = 5'h12;

  // ****************************************************************
  // modes and stop sequence states
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_SPI_MASTER = 4'h0,
    MODE_SPI_SLAVE = 4'h4,
    MODE_I2C_SLAVE7 = 4'h6,
    MODE_I2C_SLAVE10 = 4'h7,
    MODE_I2C_MASTER = 4'h8
  } ssp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SDA_LOW = 3'h1,
    ST_SCL_REL = 3'h3,
    ST_HOLD = 3'h2,
    ST_SDA_REL = 3'h6
  } ssp_stop_t;

endpackage

// File: rtl/ssp_baud_counter.sv
// baud down-counter, stepped at half the mclk rate
// assumes reload and run come from flops on the same clock
`timescale 1ns/100ps
module ssp_baud_counter
  import ssp_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reload,
  input wire logic run,
  input wire logic [W-1:0] divider,
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic pre;
  } ssp_bc_t;

  ssp_bc_t q;
  ssp_bc_t n;

  // expiry once per half period of the serial clock
  assign tick = run && q.pre && (q.cnt == '0) && !reload;

  // ****************************************************************
  // count logic
  // ****************************************************************
  always_comb begin
    n = q;
    if (reload) begin
      n.cnt = divider;
      n.pre = 1'b0;
    end else if (run) begin
      n.pre = ~q.pre;
      if (q.pre) begin
        if (q.cnt == '0) begin
          n.cnt = divider;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
    end
  end

  // state register; holds its value while run and reload are low
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule

// File: rtl/ssp_core.sv
// serial port core: registers, baud clock, stop sequence, collisions
// assumes open-drain scl/sda resolved outside, Avalon-MM master on bus
//
// How it works
// - sda low after stop count means collision
// - scl low before sda rises means collision
// - stop: sda low, release scl, count, sample
// - buffer write in an enabled master mode reloads and starts baud counter
// - idle baud counter stops, clock pin holds
// - divider reloaded every serial half period
// - serial period is four times divider plus one
// - counter steps at half mclk rate
// - seven-bit address in divider bits 7:1
// - ten-bit high byte uses bits 2:1
// - ten-bit low byte uses all bits
// - mask bits 7:1 select compared bits
// - mask bit zero only in ten-bit mode
// - spi master sample phase from smp bit
// - two-wire smp selects slew rate control
// - spi clock edge bit picks shift edge
// - two-wire clock edge bit selects thresholds
// - data/address flag shows last byte kind
// - stop flag set when stop seen last
// - start/stop flags cleared by reset, disable
// - collision sets flag, returns port idle
// - collision aborts stop, releases lines
`timescale 1ns/100ps
module ssp_core
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic sck_out,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_is_addr,
  input wire logic rx_hi_byte,
  output logic addr_match,
  output logic collision,
  output logic spi_sample_end,
  output logic spi_shift_on_idle,
  output logic slew_enable,
  output logic smbus_inputs
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [7:0] buf_r;
    logic [7:0] div_r;
    logic [7:0] mask_r;
    logic sample_phase_bit;
    logic cke;
    logic da;
    logic p;
    logic s;
    logic bf;
    logic [3:0] mode;
    logic en;
    logic stop_req;
    logic coll;
    ssp_stop_t st;
    logic [4:0] run_cnt;
    logic clk_lvl;
    logic scl_oe;
    logic sda_oe;
    logic sck;
    logic load;
    logic wait_r;
    logic [7:0] rdata;
    logic match;
    logic smp_spi;
    logic cke_spi;
    logic slew;
    logic smbus;
  } ssp_state_t;

  ssp_state_t q;
  ssp_state_t n;
  logic tick;
  logic brg_run;
  logic spi_m;
  logic i2c_m;
  logic i2c_any;
  logic spi_any;
  logic wr;
  logic rd;
  logic coll_ev;
  logic [7:0] stat_v;
  logic [7:0] ctrl_v;
  logic [7:0] diff;
  logic [7:0] cmp;

  // ****************************************************************
  // mode decode and baud counter
  // ****************************************************************
  assign spi_m = (q.mode == MODE_SPI_MASTER);
  assign i2c_m = (q.mode == MODE_I2C_MASTER);
  assign spi_any = spi_m || (q.mode == MODE_SPI_SLAVE);
  assign i2c_any = !spi_any;
  assign brg_run = (q.run_cnt != 5'h00) || (q.st == ST_HOLD) ||
                   (q.st == ST_SDA_REL);

  ssp_baud_counter #(
    .W(8)
  ) u_brg (
    .mclk(mclk),
    .rst(rst),
    .reload(q.load),
    .run(brg_run),
    .divider(q.div_r),
    .tick(tick)
  );

  // ****************************************************************
  // register read views
  // ****************************************************************
  always_comb begin
    stat_v = 8'h00;
    stat_v[STAT_SMP] = q.sample_phase_bit;
    stat_v[STAT_CKE] = q.cke;
    stat_v[STAT_DA] = q.da;
    stat_v[STAT_P] = q.p;
    stat_v[STAT_S] = q.s;
    stat_v[STAT_RW] = (q.run_cnt != 5'h00);
    stat_v[STAT_UA] = 1'b0;
    stat_v[STAT_BF] = q.bf;
    ctrl_v = 8'h00;
    ctrl_v[CTRL_MODE_LSB +: 4] = q.mode;
    ctrl_v[CTRL_EN] = q.en;
    ctrl_v[CTRL_STOP] = q.stop_req;
    ctrl_v[CTRL_COLL] = q.coll;
  end

  // address compare, masked per slave mode
  always_comb begin
    diff = rx_byte ^ q.div_r;
    cmp = {q.mask_r[7:1], 1'b0};
    if (q.mode == MODE_I2C_SLAVE10) begin
      if (rx_hi_byte) begin
        cmp = {5'h00, q.mask_r[2:1], 1'b0};
      end else begin
        cmp = q.mask_r;
      end
    end
  end

  // bus strobes: write and read take effect when waitrequest is low
  assign wr = av_write && !q.wait_r;
  assign rd = av_read && !q.wait_r;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = q;
    n.load = 1'b0;
    coll_ev = 1'b0;

    // three-stage pin synchronisers with agreement filter
    n.scl_s = {q.scl_s[1:0], scl_in};
    n.sda_s = {q.sda_s[1:0], sda_in};
    if (q.scl_s[2] == q.scl_s[1]) begin
      n.scl_f = q.scl_s[2];
    end
    if (q.sda_s[2] == q.sda_s[1]) begin
      n.sda_f = q.sda_s[2];
    end

    if (i2c_any && q.scl_f && n.scl_f) begin
      if (n.sda_f && !q.sda_f) begin
        n.p = 1'b1;
        n.s = 1'b0;
      end else if (!n.sda_f && q.sda_f) begin
        n.s = 1'b1;
        n.p = 1'b0;
      end
    end

    // bus handshake: one wait cycle then answer
    if ((av_read || av_write) && q.wait_r) begin
      n.wait_r = 1'b0;
      case (av_address)
        IDX_BUF: n.rdata = q.buf_r;
        IDX_DIV: n.rdata = q.div_r;
        IDX_MASK: n.rdata = q.mask_r;
        IDX_STAT: n.rdata = stat_v;
        IDX_CTRL: n.rdata = ctrl_v;
        default: n.rdata = 8'h00;
      endcase
    end else begin
      n.wait_r = 1'b1;
    end

    // reading the buffer empties it
    if (rd && av_address == IDX_BUF) begin
      n.bf = 1'b0;
    end

    // received bytes from the shifter
    if (rx_valid && i2c_any && !i2c_m) begin
      n.buf_r = rx_byte;
      n.bf = 1'b1;
      n.da = !rx_is_addr;
      if (rx_is_addr) begin
        n.match = ((diff & cmp) == 8'h00);
      end
    end

    // register writes
    if (wr) begin
      case (av_address)
        IDX_BUF: begin
          n.buf_r = av_writedata[7:0];
          n.bf = 1'b1;
          if (q.en && (spi_m || i2c_m) && q.st == ST_IDLE) begin
            n.load = 1'b1;
            n.run_cnt = spi_m ? SPI_HALVES : I2C_HALVES;
          end
        end
        IDX_DIV: n.div_r = av_writedata[7:0];
        IDX_MASK: n.mask_r = av_writedata[7:0];
        IDX_STAT: begin
          n.sample_phase_bit = av_writedata[STAT_SMP];
          n.cke = av_writedata[STAT_CKE];
        end
        IDX_CTRL: begin
          n.mode = av_writedata[CTRL_MODE_LSB +: 4];
          n.en = av_writedata[CTRL_EN];
          if (av_writedata[CTRL_STOP]) begin
            n.stop_req = 1'b1;
          end
          if (av_writedata[CTRL_COLL]) begin
            n.coll = 1'b0;
          end
        end
        default: n.en = q.en;
      endcase
    end

    if (q.run_cnt != 5'h00 && tick) begin
      n.clk_lvl = ~q.clk_lvl;
      n.run_cnt = q.run_cnt - 5'h01;
      if (q.run_cnt == 5'h01) begin
        n.bf = 1'b0;
      end
    end
    if (spi_m) begin
      n.sck = n.clk_lvl;
    end else if (i2c_m && q.st == ST_IDLE) begin
      n.scl_oe = !n.clk_lvl;
    end

    // stop sequence with arbitration checks
    case (q.st)
      ST_IDLE: begin
        if (q.stop_req && i2c_m && q.en && q.run_cnt == 5'h00) begin
          n.sda_oe = 1'b1;
          n.scl_oe = 1'b1;
          n.st = ST_SDA_LOW;
        end
      end
      ST_SDA_LOW: begin
        if (!q.sda_f) begin
          n.scl_oe = 1'b0;
          n.st = ST_SCL_REL;
        end
      end
      ST_SCL_REL: begin
        if (q.scl_f) begin
          n.load = 1'b1;
          n.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!q.scl_f) begin
          coll_ev = 1'b1;
        end else if (tick) begin
          n.sda_oe = 1'b0;
          n.load = 1'b1;
          n.st = ST_SDA_REL;
        end
      end
      ST_SDA_REL: begin
        if (!q.scl_f && !q.sda_f) begin
          coll_ev = 1'b1;
        end else if (tick) begin
          if (!q.sda_f) begin
            coll_ev = 1'b1;
          end else begin
            n.stop_req = 1'b0;
            n.st = ST_IDLE;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (coll_ev) begin
      n.coll = 1'b1;
      n.st = ST_IDLE;
      n.stop_req = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.run_cnt = 5'h00;
      n.clk_lvl = 1'b1;
      n.bf = 1'b0;
    end

    if (!n.en) begin
      n.p = 1'b0;
      n.s = 1'b0;
      n.st = ST_IDLE;
      n.stop_req = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.run_cnt = 5'h00;
      n.clk_lvl = 1'b1;
    end

    n.smp_spi = spi_m && n.sample_phase_bit;
    n.cke_spi = spi_any && n.cke;
    n.slew = i2c_any && !n.sample_phase_bit;
    n.smbus = i2c_any && n.cke;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.buf_r <= BUF_RST;
      q.div_r <= DIV_RST;
      q.mask_r <= MASK_RST;
      q.mode <= MODE_RST;
      q.st <= ST_IDLE;
      q.clk_lvl <= 1'b1;
      q.wait_r <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign av_readdata = {24'h000000, q.rdata};
  assign av_waitrequest = q.wait_r;
  assign scl_out = 1'b0;  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign sck_out = q.sck;
  assign addr_match = q.match;
  assign collision = q.coll;
  assign spi_sample_end = q.smp_spi;
  assign spi_shift_on_idle = q.cke_spi;
  assign slew_enable = q.slew;
  assign smbus_inputs = q.smbus;

endmodule

// File: test/ssp_peer.sv
// two-wire bus peer: stretches scl, jams sda or scl on command
// assumes wired-and lines with pull-ups resolved by the bench
`timescale 1ns/100ps
module ssp_peer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic [3:0] stretch,
  input wire logic [1:0] jam,
  output logic scl_pull,
  output logic sda_pull
);
  // ********
  // low-time counter
  // ********
  logic [5:0] cnt_reg;
  logic [5:0] t0;
  assign t0 = {2'h0, stretch} + 6'h06;
  // cycles since sda went low, saturating
  always_ff @(posedge mclk) begin
    if (rst || sda)
      cnt_reg <= 6'h00;
    else if (cnt_reg != 6'h3F)
      cnt_reg <= cnt_reg + 6'h01;
  end
  // stretch scl, then with jam 2 also pulse it low while sda is still low
  assign scl_pull = !sda && (cnt_reg < t0 || (jam == 2'h2 &&
    cnt_reg >= t0 + 6'h06 && cnt_reg < t0 + 6'h0C));
  // hold sda low to drive a data zero over the stop
  assign sda_pull = jam == 2'h1 && cnt_reg != 6'h00 && cnt_reg < 6'h28;
endmodule

// File: test/ssp_core_asserts.sv
// port checker of the serial port core
// assumes it is bound into every ssp_core instance
`timescale 1ns/100ps
module ssp_core_asserts
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  input wire logic av_waitrequest,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sck_out,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_is_addr,
  input wire logic rx_hi_byte,
  input wire logic addr_match,
  input wire logic collision
);
  // ********
  // shadow of written registers
  // ********
  logic wl;
  logic [7:0] div_reg;
  logic [7:0] msk_reg;
  logic [3:0] mode_reg;
  logic [9:0] hc_reg;
  logic [4:0] nchg_reg;
  logic armed_reg;
  logic [7:0] lm;
  assign wl = av_write && !av_waitrequest;
  // compared bits, bit zero only in ten-bit mode
  assign lm = msk_reg & {7'h7F, mode_reg == MODE_I2C_SLAVE10};
  // capture writes, time the sck edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg <= DIV_RST;
      msk_reg <= MASK_RST;
      mode_reg <= MODE_RST;
      hc_reg <= 10'h000;
      nchg_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else begin
      if (wl && av_address == IDX_DIV)
        div_reg <= av_writedata[7:0];
      if (wl && av_address == IDX_MASK)
        msk_reg <= av_writedata[7:0];
      if (wl && av_address == IDX_CTRL)
        mode_reg <= av_writedata[3:0];
      hc_reg <= $changed(sck_out) ? 10'h000 : hc_reg + 10'h001;
      if (wl && av_address == IDX_BUF) begin
        armed_reg <= 1'b0;
        nchg_reg <= 5'h00;
      end else if ($changed(sck_out)) begin
        armed_reg <= 1'b1;
        nchg_reg <= nchg_reg + 5'h01;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ********
  // assertions
  // ********
  property p_wait_ans;
    (av_read || av_write) && av_waitrequest |=> !av_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("request not answered next cycle");
  property p_wait_one;
    !av_waitrequest |=> av_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer held longer than one cycle");
  property p_coll_rel;
    $rose(collision) |-> ##[0:1] !(scl_oe || sda_oe);
  endproperty
  a_coll_rel: assert property (p_coll_rel)
    else $error("lines still pulled after collision");
  property p_coll_hold;
    collision && !(wl && av_address == IDX_CTRL && av_writedata[6])
      |=> collision;
  endproperty
  a_coll_hold: assert property (p_coll_hold)
    else $error("collision flag lost without clear");
  property p_scl_rel;
    $fell(scl_oe) && !collision |-> $past(sda_in, 2) == 1'b0;
  endproperty
  a_scl_rel: assert property (p_scl_rel)
    else $error("scl released before sda seen low");
  property p_sck_half;
    $changed(sck_out) && armed_reg |-> hc_reg == {1'b0, div_reg, 1'b1};
  endproperty
  a_sck_half: assert property (p_sck_half)
    else $error("sck half period wrong");
  property p_sck_stop;
    $changed(sck_out) && mode_reg == MODE_SPI_MASTER
      |-> nchg_reg < SPI_HALVES;
  endproperty
  a_sck_stop: assert property (p_sck_stop)
    else $error("sck moved after transfer end");
  property p_addr;
    rx_valid && rx_is_addr && (mode_reg == MODE_I2C_SLAVE7 ||
      (mode_reg == MODE_I2C_SLAVE10 && !rx_hi_byte))
      |=> addr_match == ((($past(rx_byte) ^ div_reg) & lm) == 8'h00);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address match result wrong");
  property p_addr_hi;
    rx_valid && rx_is_addr && rx_hi_byte && mode_reg == MODE_I2C_SLAVE10
      |=> addr_match == ((($past(rx_byte) ^ div_reg) &
        {5'h00, msk_reg[2:1], 1'b0}) == 8'h00);
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("high address byte match result wrong");
endmodule
bind ssp_core ssp_core_asserts ssp_core_asserts_inst (
  .mclk(mclk), .rst(rst), .av_address(av_address),
  .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
  .av_waitrequest(av_waitrequest), .sda_in(sda_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .sck_out(sck_out), .rx_valid(rx_valid),
  .rx_byte(rx_byte), .rx_is_addr(rx_is_addr), .rx_hi_byte(rx_hi_byte),
  .addr_match(addr_match), .collision(collision)
);

// File: test/tb_top.sv
// self-checking bench of the serial port core with a two-wire peer
// assumes the checker is bound in and the peer model is compiled
`timescale 1ns/100ps
module tb_top
  import ssp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] av_address = '0;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [31:0] av_writedata = '0;
  logic [31:0] av_readdata;
  logic av_waitrequest, scl_oe, sda_oe, sck_out, scl_pull, sda_pull;
  logic addr_match, spi_sample_end, spi_shift_on_idle, slew_enable;
  logic smbus_inputs;
  logic ostb = 1'b0;
  logic rxa_d = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_is_addr = 1'b0;
  logic rx_hi_byte = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic [1:0] jam = 2'h0;
  logic [31:0] seed = 32'h00000013;
  logic [7:0] r;
  logic sck_d = 1'b0;
  logic [31:0] rq[$];
  logic [31:0] pq[$];
  logic [31:0] mq[$];
  logic [31:0] oq[$];
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int lr = 0;
  wire logic scl_w = !(scl_oe || scl_pull);
  wire logic sda_w = !(sda_oe || sda_pull);
  wire logic [3:0] mode_outs = {spi_sample_end, spi_shift_on_idle,
    slew_enable, smbus_inputs};
  initial begin
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  ssp_core ssp_core_inst (.mclk(mclk), .rst(rst),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .scl_in(scl_w), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .sck_out(sck_out), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_is_addr(rx_is_addr), .rx_hi_byte(rx_hi_byte),
    .addr_match(addr_match), .collision(),
    .spi_sample_end(spi_sample_end),
    .spi_shift_on_idle(spi_shift_on_idle), .slew_enable(slew_enable),
    .smbus_inputs(smbus_inputs));
  ssp_peer ssp_peer_inst (.mclk(mclk), .rst(rst), .scl(scl_w),
    .sda(sda_w), .stretch(stretch), .jam(jam), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  // ********
  // tasks
  // ********
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    av_address <= a;
    av_write <= w;
    av_read <= !w;
    av_writedata <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 20);
    av_write <= 1'b0;
    av_read <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic rxb(input logic [7:0] b, input logic a, input logic m);
    if (a)
      mq.push_back({31'h0, m});
    rx_byte <= b;
    rx_is_addr <= a;
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // note the expected mode outputs, strobe the watcher once
  task automatic outs(input logic [3:0] e);
    oq.push_back({28'h0, e});
    ostb <= 1'b1;
    @(posedge mclk);
    ostb <= 1'b0;
    @(posedge mclk);
  endtask
  // bounded wait on sck (sel) or sda_oe
  task automatic wsig(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? sck_out : sda_oe) !== v && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      complete_run();
    end
  endtask
  // result watcher: read data, address match, mode outputs and sck period
  always @(posedge mclk) begin
    cyc++;
    if (av_read && av_waitrequest === 1'b0)
      check(av_readdata, rq.pop_front());
    if (rxa_d)
      check({31'h0, addr_match}, mq.pop_front());
    rxa_d = rx_valid && rx_is_addr;
    if (ostb)
      check({28'h0, mode_outs}, oq.pop_front());
    if (sck_out && !sck_d) begin
      if (pq.size() > 0)
        check(32'(cyc - lr), pq.pop_front());
      lr = cyc;
    end
    sck_d = sck_out;
  end
  // ********
  // main sequence
  // ********
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(IDX_DIV, DIV_RST);
    rd(IDX_MASK, MASK_RST);
    rd(IDX_STAT, 8'h00);
    wr(10'h3FF, 8'h5A);
    rd(10'h3FF, 8'h00);
    repeat (3) begin
      r = xs();
      wr(IDX_MASK, r);
      rd(IDX_MASK, r);
    end
    wr(IDX_STAT, 8'hFF);
    rd(IDX_STAT, 8'hC0);
    outs(4'hC);
    // sample phase cleared before spi slave mode
    wr(IDX_STAT, 8'h40);
    wr(IDX_CTRL, 8'h04);
    outs(4'h4);
    wr(IDX_STAT, 8'h00);
    // divider kept at three or above
    wr(IDX_DIV, 8'h03);
    // stop: slow clean, sda jammed, scl jammed
    for (int j = 0; j < 3; j++) begin
      stretch <= 4'(6 - 3 * j);
      jam <= 2'(j);
      wr(IDX_CTRL, 8'h78);
      wsig(1'b0, 1'b1);
      wsig(1'b0, 1'b0);
      repeat (50) @(posedge mclk);
      rd(IDX_CTRL, (j == 0) ? 8'h18 : 8'h58);
      if (j == 0)
        rd(IDX_STAT, 8'h10);
    end
    wr(IDX_CTRL, 8'h08);
    rd(IDX_STAT, 8'h00);
    wr(IDX_CTRL, 8'h16);
    wr(IDX_STAT, 8'hC0);
    outs(4'h1);
    wr(IDX_STAT, 8'h00);
    outs(4'h2);
    wr(IDX_DIV, 8'hA4);
    wr(IDX_MASK, 8'hF0);
    rxb(8'hA5, 1'b1, 1'b1);
    rxb(8'hAC, 1'b1, 1'b1);
    rxb(8'h34, 1'b1, 1'b0);
    rd(IDX_STAT, 8'h01);
    rxb(8'h5A, 1'b0, 1'b0);
    rd(IDX_STAT, 8'h21);
    rd(IDX_BUF, 8'h5A);
    rd(IDX_STAT, 8'h20);
    // ten-bit low byte with mask bit zero
    wr(IDX_CTRL, 8'h17);
    wr(IDX_MASK, 8'hF1);
    rxb(8'hA4, 1'b1, 1'b1);
    rxb(8'hA5, 1'b1, 1'b0);
    repeat (4) begin
      r = xs();
      rxb(r, 1'b1, ((r ^ 8'hA4) & 8'hF1) == 8'h00);
    end
    rd(IDX_BUF, r);
    // ten-bit high byte uses bits 2:1
    wr(IDX_MASK, 8'hFF);
    rx_hi_byte <= 1'b1;
    rxb(8'h5D, 1'b1, 1'b1);
    rxb(8'hFB, 1'b1, 1'b0);
    rx_hi_byte <= 1'b0;
    // buffer write starts the spi clock
    wr(IDX_CTRL, 8'h10);
    repeat (2) begin
      r = 8'h03 + (xs() & 8'h07);
      wr(IDX_DIV, r);
      wr(IDX_BUF, xs());
      // time from the first rising edge of this transfer
      wsig(1'b1, 1'b0);
      wsig(1'b1, 1'b1);
      @(posedge mclk);
      pq.push_back(32'(4 * (int'(r) + 1)));
      repeat (40 * (int'(r) + 1)) @(posedge mclk);
    end
    complete_run();
  end
endmodule
